// ===== hw/pamon_regs.svh
// register map, field positions and timing constants for the pa power monitor
// How it works
// - long-window power bits 12..8 read back; upper three bits read zero
// - power is I squared plus Q squared from six top sample bits
// - 13-bit short threshold split over low and high registers, used in compare
// - short averaging and error detection run only while control bit 7 set
// - short window spans two to the power of the two-bit length field
// - pa period: 4 or 8 times main interpolation, else 32 clocks
// - short-window average reads back as low byte plus five high bits
// - paged registers reach the paths chosen by the page select bits at 0x008
// - transmit state machine runs only while its enable bit 0 is set
// - override bit 2 takes transmit enable from register instead of pin
// - under override, bit 3 is the transmit enable status
// - short power error triggers soft off when its enable bit 7 set
// - falling effective transmit enable triggers soft off when bit 1 set
`ifndef PAMON_REGS_SVH
`define PAMON_REGS_SVH

`define PAMON_NPATH        2
`define PAMON_A_PAGE       12'h008
`define PAMON_A_SOFTOFF    12'h581
`define PAMON_A_LONG_HI    12'h587
`define PAMON_A_THR_LO     12'h588
`define PAMON_A_THR_HI     12'h589
`define PAMON_A_SCTL       12'h58A
`define PAMON_A_SPWR_LO    12'h58B
`define PAMON_A_SPWR_HI    12'h58C
`define PAMON_A_SM         12'h58D
`define PAMON_A_BLANK      12'h596

`define PAMON_PAGE_RST     2'h1
`define PAMON_SOFTOFF_RST  1'h1
`define PAMON_SHORT_EN_BIT 7
`define PAMON_SO_SHORT_BIT 7
`define PAMON_SO_TXEN_BIT  1
`define PAMON_SM_EN_BIT    0
`define PAMON_OVR_EN_BIT   2
`define PAMON_OVR_VAL_BIT  3

`define PAMON_SMP_MSB      15
`define PAMON_SMP_BITS     6
`define PAMON_LONG_LOG2    9

`define PAMON_MAIN_MULT    8'h04
`define PAMON_CHAN_MULT    8'h08
`define PAMON_BASE_PERIOD  8'h20

`endif

// ===== hw/pamon_pkg.sv
// types shared by the pa power monitor modules
`default_nettype none
package pamon_pkg;
   typedef logic [12:0] pamon_pwr_t;
   typedef enum logic [2:0] {
      SM_IDLE   = 3'b001,
      SM_ACTIVE = 3'b010,
      SM_RAMP   = 3'b100
   } pamon_sm_e;
endpackage : pamon_pkg
`default_nettype wire

// ===== hw/pamon_if.sv
// link between the control top and one power detector path
`timescale 1ns/1ps
`default_nettype none
interface pamon_if;
   import pamon_pkg::*;
   logic        tick;
   logic        short_en;
   logic [1:0]  avg_len;
   pamon_pwr_t  thr;
   logic [15:0] i_smp;
   logic [15:0] q_smp;
   pamon_pwr_t  short_pwr;
   pamon_pwr_t  long_pwr;
   logic        short_err;
   logic        err_rise;
   modport ctrl (output tick, short_en, avg_len, thr, i_smp, q_smp,
                 input  short_pwr, long_pwr, short_err, err_rise);
   modport path (input  tick, short_en, avg_len, thr, i_smp, q_smp,
                 output short_pwr, long_pwr, short_err, err_rise);
endinterface : pamon_if
`default_nettype wire

// ===== hw/pamon_power_det.sv
// short and long window power detector for one dac path
`timescale 1ns/1ps
`default_nettype none
`include "pamon_regs.svh"
module pamon_power_det
   import pamon_pkg::*;
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   // control and results
   pamon_if.path     pm
);
   logic signed [11:0] i_ext;
   logic signed [11:0] q_ext;
   logic [11:0]        i_sq;
   logic [11:0]        q_sq;
   logic [12:0]        pwr_now;
   logic [15:0]        s_acc;
   logic [15:0]        next_s_acc;
   logic [2:0]         s_cnt;
   logic [2:0]         win_last;
   logic               s_last;
   pamon_pwr_t         s_avg;
   logic [20:0]        l_acc;
   logic [20:0]        next_l_acc;
   logic [8:0]         l_cnt;
   pamon_pwr_t         short_pwr;
   pamon_pwr_t         long_pwr;
   logic               short_err;
   logic               err_rise;

   assign i_ext = {{(12-`PAMON_SMP_BITS){pm.i_smp[`PAMON_SMP_MSB]}},
                   pm.i_smp[`PAMON_SMP_MSB -: `PAMON_SMP_BITS]};
   assign q_ext = {{(12-`PAMON_SMP_BITS){pm.q_smp[`PAMON_SMP_MSB]}},
                   pm.q_smp[`PAMON_SMP_MSB -: `PAMON_SMP_BITS]};
   assign i_sq       = i_ext * i_ext;
   assign q_sq       = q_ext * q_ext;
   assign pwr_now    = {1'b0, i_sq} + {1'b0, q_sq};
   assign next_s_acc = s_acc + 16'(pwr_now);
   assign win_last   = 3'((4'h1 << pm.avg_len) - 4'h1);
   // shortening the window mid-count must not strand the counter
   assign s_last     = (s_cnt >= win_last);
   assign s_avg      = 13'(next_s_acc >> pm.avg_len);
   assign next_l_acc = l_acc + 21'(pwr_now);

   // short window; disabling drops the partial window, readback keeps last value
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_acc     <= 16'h0000;
         s_cnt     <= 3'h0;
         short_pwr <= 13'h0000;
         short_err <= 1'b0;
         err_rise  <= 1'b0;
      end else begin
         err_rise <= 1'b0;
         if (!pm.short_en) begin
            s_acc     <= 16'h0000;
            s_cnt     <= 3'h0;
            short_err <= 1'b0;
         end else if (pm.tick) begin
            if (s_last) begin
               s_acc     <= 16'h0000;
               s_cnt     <= 3'h0;
               short_pwr <= s_avg;
               short_err <= (s_avg > pm.thr);
               err_rise  <= (s_avg > pm.thr) && !short_err;
            end else begin
               s_acc <= next_s_acc;
               s_cnt <= s_cnt + 3'h1;
            end
         end
      end
   end

   // long window has a fixed length while its own controls are absent
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         l_acc    <= 21'h000000;
         l_cnt    <= 9'h000;
         long_pwr <= 13'h0000;
      end else if (pm.tick) begin
         l_cnt <= l_cnt + 9'h001;
         if (&l_cnt) begin
            l_acc    <= 21'h000000;
            long_pwr <= {1'b0, next_l_acc[20:`PAMON_LONG_LOG2]};
         end else begin
            l_acc <= next_l_acc;
         end
      end
   end

   assign pm.short_pwr = short_pwr;
   assign pm.long_pwr  = long_pwr;
   assign pm.short_err = short_err;
   assign pm.err_rise  = err_rise;

   a_err_compare: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (pm.short_en && pm.tick && s_last) |=>
         (short_err == ($past(s_avg) > $past(pm.thr)) && short_pwr == $past(s_avg)))
      else $error("short error or readback wrong after window end");

   a_disable_quiet: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (!pm.short_en) |=> (!short_err && !err_rise && s_cnt == 3'h0))
      else $error("short detection active while disabled");

endmodule : pamon_power_det
`default_nettype wire

// ===== hw/pamon_top.sv
// paged power monitor and transmit enable control for two dac paths
`timescale 1ns/1ps
`default_nettype none
`include "pamon_regs.svh"
module pamon_top
   import pamon_pkg::*;
(
   // clock and reset
   input  wire logic        MCLK_I,
   input  wire logic        ARST_N_I,
   // register port
   input  wire logic [11:0] REG_ADDR_I,
   input  wire logic [7:0]  REG_WDATA_I,
   input  wire logic        REG_WR_I,
   input  wire logic        REG_RD_I,
   output      logic [7:0]  REG_RDATA_O,
   // interpolation settings
   input  wire logic [3:0]  MAIN_INTERP_I,
   input  wire logic [3:0]  CHAN_INTERP_I,
   // sample buses, path 1 in the upper half
   input  wire logic [31:0] DATA_I_I,
   input  wire logic [31:0] DATA_Q_I,
   // transmit enable pins
   input  wire logic [1:0]  TXEN_I,
   // protection outputs
   output      logic [1:0]  TX_ENABLE_O,
   output      logic [1:0]  SHORT_ERR_O,
   output      logic [1:0]  SOFT_OFF_O
);
   localparam int NP = `PAMON_NPATH;

   logic [1:0]  page;
   logic [7:0]  thr_lo     [NP];
   logic [4:0]  thr_hi     [NP];
   logic        short_en   [NP];
   logic [1:0]  avg_len    [NP];
   logic [7:0]  sm_ctl     [NP];
   logic        ovr_en     [NP];
   logic        ovr_val    [NP];
   logic        so_short   [NP];
   logic        so_txen    [NP];
   pamon_pwr_t  short_pwr  [NP];
   pamon_pwr_t  long_pwr   [NP];
   logic [1:0]  short_err;
   logic [1:0]  err_rise;
   logic [7:0]  pa_period;
   logic [7:0]  pa_cnt;
   logic        pa_tick;
   logic [7:0]  gap;
   logic        tick_seen;
   logic [1:0]  txen_meta;
   logic [1:0]  txen_sync;
   logic [1:0]  eff;
   logic [1:0]  eff_prev;
   logic [1:0]  fall;
   pamon_sm_e   st         [NP];
   pamon_sm_e   next_st    [NP];
   int unsigned rp;

   // pa clock period from interpolation settings
   always_comb begin
      if (MAIN_INTERP_I > 4'h1) begin
         pa_period = 8'(MAIN_INTERP_I) * `PAMON_MAIN_MULT;
      end else if (CHAN_INTERP_I > 4'h1) begin
         pa_period = 8'(MAIN_INTERP_I) * `PAMON_CHAN_MULT;
      end else begin
         pa_period = `PAMON_BASE_PERIOD;
      end
   end

   // compare with >= so a shrinking period never strands the counter
   assign pa_tick = (pa_cnt >= pa_period - 8'h01);

   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         pa_cnt <= 8'h00;
      end else if (pa_tick) begin
         pa_cnt <= 8'h00;
      end else begin
         pa_cnt <= pa_cnt + 8'h01;
      end
   end

   // register writes land on every path whose page bit is set
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         page <= `PAMON_PAGE_RST;
         for (int p = 0; p < NP; p++) begin
            thr_lo[p]   <= 8'h00;
            thr_hi[p]   <= 5'h00;
            short_en[p] <= 1'b0;
            avg_len[p]  <= 2'h0;
            sm_ctl[p]   <= 8'h00;
            ovr_en[p]   <= 1'b0;
            ovr_val[p]  <= 1'b0;
            so_short[p] <= `PAMON_SOFTOFF_RST;
            so_txen[p]  <= `PAMON_SOFTOFF_RST;
         end
      end else if (REG_WR_I) begin
         if (REG_ADDR_I == `PAMON_A_PAGE) begin
            page <= REG_WDATA_I[1:0];
         end
         for (int p = 0; p < NP; p++) begin
            if (page[p]) begin
               case (REG_ADDR_I)
                  `PAMON_A_SOFTOFF: begin
                     so_short[p] <= REG_WDATA_I[`PAMON_SO_SHORT_BIT];
                     so_txen[p]  <= REG_WDATA_I[`PAMON_SO_TXEN_BIT];
                  end
                  `PAMON_A_THR_LO: thr_lo[p] <= REG_WDATA_I;
                  `PAMON_A_THR_HI: thr_hi[p] <= REG_WDATA_I[4:0];
                  `PAMON_A_SCTL: begin
                     short_en[p] <= REG_WDATA_I[`PAMON_SHORT_EN_BIT];
                     avg_len[p]  <= REG_WDATA_I[1:0];
                  end
                  `PAMON_A_SM: sm_ctl[p] <= REG_WDATA_I;
                  `PAMON_A_BLANK: begin
                     ovr_en[p]  <= REG_WDATA_I[`PAMON_OVR_EN_BIT];
                     ovr_val[p] <= REG_WDATA_I[`PAMON_OVR_VAL_BIT];
                  end
                  default: ;
               endcase
            end
         end
      end
   end

   // reads come from the lowest selected path
   assign rp = page[0] ? 0 : 1;

   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         REG_RDATA_O <= 8'h00;
      end else if (REG_RD_I) begin
         case (REG_ADDR_I)
            `PAMON_A_PAGE:    REG_RDATA_O <= {6'h00, page};
            `PAMON_A_SOFTOFF: REG_RDATA_O <= {so_short[rp], 5'h00, so_txen[rp], 1'b0};
            `PAMON_A_LONG_HI: REG_RDATA_O <= {3'h0, long_pwr[rp][12:8]};
            `PAMON_A_THR_LO:  REG_RDATA_O <= thr_lo[rp];
            `PAMON_A_THR_HI:  REG_RDATA_O <= {3'h0, thr_hi[rp]};
            `PAMON_A_SCTL:    REG_RDATA_O <= {short_en[rp], 5'h00, avg_len[rp]};
            `PAMON_A_SPWR_LO: REG_RDATA_O <= short_pwr[rp][7:0];
            `PAMON_A_SPWR_HI: REG_RDATA_O <= {3'h0, short_pwr[rp][12:8]};
            `PAMON_A_SM:      REG_RDATA_O <= sm_ctl[rp];
            `PAMON_A_BLANK:   REG_RDATA_O <= {4'h0, ovr_val[rp], ovr_en[rp], 2'h0};
            default:          REG_RDATA_O <= 8'h00;
         endcase
      end
   end

   // one detector per path
   for (genvar g = 0; g < NP; g++) begin : gen_path
      pamon_if pm ();
      assign pm.tick     = pa_tick;
      assign pm.short_en = short_en[g];
      assign pm.avg_len  = avg_len[g];
      assign pm.thr      = {thr_hi[g], thr_lo[g]};
      assign pm.i_smp    = DATA_I_I[16*g +: 16];
      assign pm.q_smp    = DATA_Q_I[16*g +: 16];
      assign short_pwr[g] = pm.short_pwr;
      assign long_pwr[g]  = pm.long_pwr;
      assign short_err[g] = pm.short_err;
      assign err_rise[g]  = pm.err_rise;

      pamon_power_det u_det (
         .clk_i    (MCLK_I),
         .arst_n_i (ARST_N_I),
         .pm       (pm.path)
      );
   end

   assign SHORT_ERR_O = short_err;

   // pins are asynchronous to the dac clock
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         txen_meta <= 2'h0;
         txen_sync <= 2'h0;
      end else begin
         txen_meta <= TXEN_I;
         txen_sync <= txen_meta;
      end
   end

   always_comb begin
      for (int p = 0; p < NP; p++) begin
         eff[p] = ovr_en[p] ? ovr_val[p] : txen_sync[p];
      end
   end

   assign fall = eff_prev & ~eff;

   always_comb begin
      for (int p = 0; p < NP; p++) begin
         next_st[p] = st[p];
         if (!sm_ctl[p][`PAMON_SM_EN_BIT]) begin
            next_st[p] = SM_IDLE;
         end else begin
            case (st[p])
               SM_IDLE:   if (eff[p]) next_st[p] = SM_ACTIVE;
               SM_ACTIVE: if (!eff[p]) next_st[p] = SM_RAMP;
               // output stays on for the ramp until the next pa tick
               SM_RAMP:   if (pa_tick) next_st[p] = SM_IDLE;
               default:   next_st[p] = SM_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         eff_prev    <= 2'h0;
         TX_ENABLE_O <= 2'h0;
         for (int p = 0; p < NP; p++) begin
            st[p] <= SM_IDLE;
         end
      end else begin
         eff_prev <= eff;
         for (int p = 0; p < NP; p++) begin
            st[p] <= next_st[p];
            if (sm_ctl[p][`PAMON_SM_EN_BIT]) begin
               TX_ENABLE_O[p] <= (next_st[p] != SM_IDLE);
            end else begin
               TX_ENABLE_O[p] <= eff[p];
            end
         end
      end
   end

   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         SOFT_OFF_O <= 2'h0;
      end else begin
         for (int p = 0; p < NP; p++) begin
            SOFT_OFF_O[p] <= (so_short[p] && err_rise[p])
                          || (so_txen[p] && fall[p]);
         end
      end
   end

   // helper: cycles since the previous pa tick
   always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         gap       <= 8'h00;
         tick_seen <= 1'b0;
      end else if (pa_tick) begin
         gap       <= 8'h00;
         tick_seen <= 1'b1;
      end else begin
         gap <= gap + 8'h01;
      end
   end

   a_tick_period: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      (pa_tick && tick_seen && $stable(MAIN_INTERP_I) && $stable(CHAN_INTERP_I))
         |-> (gap == pa_period - 8'h01))
      else $error("pa tick spacing differs from period");

   a_sm_disabled: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      (!sm_ctl[0][`PAMON_SM_EN_BIT]) |=> (st[0] == SM_IDLE))
      else $error("state machine left idle while disabled");

   a_override_out: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      (!sm_ctl[0][`PAMON_SM_EN_BIT] && ovr_en[0]) |=> (TX_ENABLE_O[0] == $past(ovr_val[0])))
      else $error("transmit enable ignores software value");

   a_pin_path: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      (!ovr_en[0] && !sm_ctl[0][`PAMON_SM_EN_BIT]) |=> (TX_ENABLE_O[0] == $past(txen_sync[0])))
      else $error("transmit enable does not follow pin");

   a_softoff_fall: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      (so_txen[0] && eff_prev[0] && !eff[0]) |=> SOFT_OFF_O[0])
      else $error("no soft off on transmit enable fall");

   a_softoff_err: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      (err_rise[0] && so_short[0]) |=> SOFT_OFF_O[0])
      else $error("no soft off on short power error");

   a_page_write: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      (REG_WR_I && REG_ADDR_I == `PAMON_A_THR_LO && !page[0]) |=> $stable(thr_lo[0]))
      else $error("write reached an unselected path");

   a_long_read: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      (REG_RD_I && REG_ADDR_I == `PAMON_A_LONG_HI) |=>
         (REG_RDATA_O == {3'h0, $past(long_pwr[rp][12:8])}))
      else $error("long power high byte readback wrong");

   a_ramp_hold: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      (sm_ctl[0][`PAMON_SM_EN_BIT] && st[0] == SM_ACTIVE && !eff[0])
         |=> (st[0] == SM_RAMP && TX_ENABLE_O[0]))
      else $error("transmit enable dropped without ramp");

   a_short_read: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      (REG_RD_I && REG_ADDR_I == `PAMON_A_SPWR_LO) |=>
         (REG_RDATA_O == $past(short_pwr[rp][7:0])))
      else $error("short power low byte readback wrong");

   a_thr_write: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
      (REG_WR_I && REG_ADDR_I == `PAMON_A_THR_HI && page[0]) |=>
         (thr_hi[0] == $past(REG_WDATA_I[4:0])))
      else $error("threshold high bits not written");

endmodule : pamon_top
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the paged pa power monitor and transmit enable control
`timescale 1ns/1ps
`default_nettype none
`include "pamon_regs.svh"
module tb;
   import pamon_pkg::*;
   typedef struct {logic [11:0] a; logic [7:0] d;} pamon_note_s;
   localparam logic [11:0] RA [9] = '{12'h008, 12'h581, 12'h587, 12'h588, 12'h589,
                                       12'h58A, 12'h58B, 12'h58D, 12'h596};
   localparam logic [7:0]  RV [9] = '{8'h01, 8'h82, 8'h00, 8'h00, 8'h00,
                                       8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [11:0] WA [6] = '{12'h589, 12'h58A, 12'h596, 12'h58B, 12'h590, 12'h58D};
   localparam logic [7:0]  WD [6] = '{8'hFF, 8'h7F, 8'hF3, 8'hFF, 8'hFF, 8'hFE};
   localparam logic [7:0]  WE [6] = '{8'h1F, 8'h03, 8'h00, 8'h00, 8'h00, 8'hFE};
   localparam int          PM [5] = '{1, 2, 4, 1, 6};
   localparam int          PC [5] = '{1, 2, 1, 2, 1};
   localparam int          PP [5] = '{32, 8, 16, 8, 24};
   logic        clk;
   logic        arst_n;
   logic [11:0] addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic [3:0]  mi;
   logic [3:0]  ci;
   logic [31:0] di;
   logic [31:0] dq;
   logic [1:0]  txen;
   logic [1:0]  tx_en;
   logic [1:0]  s_err;
   logic [1:0]  s_off;
   logic        rd_seen;
   int          err_count;
   int          check_count;
   pamon_note_s notes [$];
   pamon_note_s note;
   logic [12:0] p;
   logic [12:0] thr;
   logic [15:0] vi;
   logic [15:0] vq;
   int          n;
   int          seed_v;

   pamon_top DUT (
      .MCLK_I        (clk),
      .ARST_N_I      (arst_n),
      .REG_ADDR_I    (addr),
      .REG_WDATA_I   (wdata),
      .REG_WR_I      (wr),
      .REG_RD_I      (rd),
      .REG_RDATA_O   (rdata),
      .MAIN_INTERP_I (mi),
      .CHAN_INTERP_I (ci),
      .DATA_I_I      (di),
      .DATA_Q_I      (dq),
      .TXEN_I        (txen),
      .TX_ENABLE_O   (tx_en),
      .SHORT_ERR_O   (s_err),
      .SOFT_OFF_O    (s_off)
   );

   task automatic print_verdict();
      if (err_count == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk_pin(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_pin

   task automatic chk_reg(input logic [11:0] a, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR reg %h expected %h seen %h", a, e, g);
      end
   endtask : chk_reg

   // read data is due one cycle after the strobe edge
   always @(posedge clk) rd_seen <= rd;
   always @(negedge clk) begin
      if (rd_seen === 1'b1) begin
         note = notes.pop_front();
         chk_reg(note.a, note.d, rdata);
      end
   end

   // ends between edges so registered outputs have settled
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      @(negedge clk);
   endtask : cyc

   // strobe ends one edge before the next task can raise it again
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
      notes.push_back('{a, e});
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
   endtask : rd_reg

   task automatic smp(input logic [15:0] i0, input logic [15:0] q0);
      @(posedge clk);
      di <= {di[31:16], i0};
      dq <= {dq[31:16], q0};
   endtask : smp

   task automatic rst();
      arst_n <= 1'b0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
   endtask : rst

   function automatic logic [12:0] pwr(input logic [15:0] i, input logic [15:0] q);
      int a;
      int b;
      a = $signed(i[15:10]);
      b = $signed(q[15:10]);
      return 13'(a * a + b * b);
   endfunction : pwr

   // threshold 0: high samples raise the error, zero samples drop it one window later
   task automatic meas(input int w, input logic so);
      int k;
      k = 0;
      smp(16'h7C00, 16'h0000);
      do begin
         @(negedge clk);
         k++;
      end while (s_err[0] !== 1'b1 && k < 3000);
      @(posedge clk);
      di[15:0] <= 16'h0000;
      @(negedge clk);
      chk_pin("soft_off", {15'h0, so}, {15'h0, s_off[0]});
      k = 1;
      while (s_err[0] === 1'b1 && k < 3000) begin
         @(negedge clk);
         k++;
      end
      chk_pin("window", 16'(w), 16'(k));
   endtask : meas

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // longest run is about 11000 cycles, limit at 50000
   initial begin
      #250000;
      err_count++;
      print_verdict();
   end

   initial begin
      arst_n = 1'b0;
      addr = 12'h000;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      mi = 4'h2;
      ci = 4'h1;
      di = 32'h0000_0000;
      dq = 32'h0000_0000;
      txen = 2'b00;
      err_count = 0;
      check_count = 0;
      seed_v = $urandom(32'hE40B);
      rst();
      for (int k = 0; k < 9; k++) rd_reg(RA[k], RV[k]);
      for (int k = 0; k < 6; k++) begin
         wr_reg(WA[k], WD[k]);
         rd_reg(WA[k], WE[k]);
      end
      wr_reg(12'h589, 8'h00);
      wr_reg(12'h58A, 8'h00);
      wr_reg(12'h58D, 8'h00);
      // paging and broadcast
      wr_reg(12'h008, 8'h02);
      wr_reg(12'h588, 8'h5A);
      rd_reg(12'h588, 8'h5A);
      wr_reg(12'h008, 8'h01);
      rd_reg(12'h588, 8'h00);
      wr_reg(12'h008, 8'h03);
      wr_reg(12'h588, 8'hA5);
      wr_reg(12'h008, 8'h02);
      rd_reg(12'h588, 8'hA5);
      wr_reg(12'h596, 8'h0C);
      cyc(3);
      chk_pin("tx_enable", 16'h2, {14'h0, tx_en});
      wr_reg(12'h596, 8'h00);
      wr_reg(12'h008, 8'h01);
      wr_reg(12'h588, 8'h00);
      // pin versus override
      txen <= 2'b01;
      cyc(4);
      chk_pin("tx_enable", 16'h1, {14'h0, tx_en});
      wr_reg(12'h596, 8'h04);
      cyc(3);
      chk_pin("tx_enable", 16'h0, {14'h0, tx_en});
      wr_reg(12'h596, 8'h0C);
      txen <= 2'b00;
      cyc(4);
      chk_pin("tx_enable", 16'h1, {14'h0, tx_en});
      wr_reg(12'h596, 8'h00);
      cyc(3);
      chk_pin("tx_enable", 16'h0, {14'h0, tx_en});
      // state machine holds output through the ramp
      wr_reg(12'h58D, 8'h01);
      txen <= 2'b01;
      cyc(5);
      chk_pin("tx_enable", 16'h1, {14'h0, tx_en});
      @(posedge clk);
      txen <= 2'b00;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (s_off[0] !== 1'b1 && n < 12);
      chk_pin("soft_off", 16'h1, {15'h0, s_off[0]});
      chk_pin("tx_enable", 16'h1, {15'h0, tx_en[0]});
      cyc(40);
      chk_pin("tx_enable", 16'h0, {15'h0, tx_en[0]});
      wr_reg(12'h58D, 8'h00);
      // window length, pa period and soft-off on error
      for (int k = 0; k < 4; k++) begin
         wr_reg(12'h58A, 8'h80 | 8'(k));
         meas(8 << k, 1'b1);
      end
      wr_reg(12'h58A, 8'h80);
      wr_reg(12'h581, 8'h02);
      meas(8, 1'b0);
      for (int k = 0; k < 5; k++) begin
         @(posedge clk);
         mi <= 4'(PM[k]);
         ci <= 4'(PC[k]);
         rst();
         wr_reg(12'h58A, 8'h80);
         meas(PP[k], 1'b1);
      end
      @(posedge clk);
      mi <= 4'h2;
      ci <= 4'h1;
      rst();
      // disabling freezes readback and clears the error
      wr_reg(12'h58A, 8'h80);
      smp(16'h7C00, 16'h0000);
      cyc(40);
      chk_pin("short_err", 16'h1, {15'h0, s_err[0]});
      wr_reg(12'h58A, 8'h00);
      cyc(1);
      chk_pin("short_err", 16'h0, {15'h0, s_err[0]});
      smp(16'h0000, 16'h0000);
      cyc(40);
      rd_reg(12'h58B, 8'hC1);
      rd_reg(12'h58C, 8'h03);
      // random samples, threshold at and one below the average
      for (int k = 0; k < 6; k++) begin
         vi = 16'($urandom);
         vq = 16'($urandom);
         p = pwr(vi, vq);
         thr = k[0] ? p : p - 13'h1;
         wr_reg(12'h588, thr[7:0]);
         wr_reg(12'h589, {3'h0, thr[12:8]});
         wr_reg(12'h58A, 8'h80 | 8'($urandom % 4));
         di[31:16] <= 16'($urandom);
         smp(vi, vq);
         cyc(150);
         chk_pin("short_err", {15'h0, p > thr}, {15'h0, s_err[0]});
         rd_reg(12'h58B, p[7:0]);
         rd_reg(12'h58C, {3'h0, p[12:8]});
      end
      cyc(1100 * 8);
      rd_reg(12'h587, {3'h0, p[12:8]});
      cyc(4);
      print_verdict();
   end
endmodule : tb
`default_nettype wire
